// File: inc/mem_port_if.sv
// Port between the serial front end and the byte store
`timescale 1ns/10ps
interface mem_port_if;
    import sram_spi_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [DATA_W-1:0] rdata;
    modport ctrl (output addr, output wdata, output wr_en, output rd_en, input rdata);
    modport store (input addr, input wdata, input wr_en, input rd_en, output rdata);
endinterface

// File: inc/sram_spi_pkg.sv
// Constants and types shared by the serial SRAM slave and its store
package sram_spi_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 8192;
    localparam int SYNC_W = 4;
    localparam int PAGE_BITS = 5;

    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] READ_STATUS_CMD = 8'h05;
    localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;

    localparam logic [1:0] MODE_BYTE = 2'h0;
    localparam logic [1:0] MODE_SEQ = 2'h1;
    localparam logic [1:0] MODE_PAGE = 2'h2;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic HOLD_DIS_RESET = 1'b0;

    localparam int STAT_MODE_HI = 7;
    localparam int STAT_MODE_LO = 6;
    localparam int STAT_HOLD_BIT = 0;
    localparam logic [3:0] STAT_RSVD_VAL = 4'h0;
    localparam logic STAT_ONE_VAL = 1'b1;

    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] ADDR_LAST = 4'hF;

    localparam int SYNC_CS = 0;
    localparam int SYNC_SCK = 1;
    localparam int SYNC_SI = 2;
    localparam int SYNC_HOLD = 3;

    typedef enum logic [6:0] {
        ST_CMD     = 7'h01,
        ST_ADDR    = 7'h02,
        ST_WR      = 7'h04,
        ST_RD      = 7'h08,
        ST_STAT_WR = 7'h10,
        ST_STAT_RD = 7'h20,
        ST_IGNORE  = 7'h40
    } seq_state_t;
endpackage

// File: src/byte_store.sv
// Byte array of the SRAM with registered read data
`timescale 1ns/10ps
module byte_store (
    input wire logic ref_clk,
    mem_port_if.store port
);
    import sram_spi_pkg::*;

    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic [DATA_W-1:0] rdata_r;

    always_ff @(posedge ref_clk) begin
        if (port.wr_en) begin
            mem[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (port.rd_en) begin
            rdata_r <= mem[port.addr];
        end
    end

    assign port.rdata = rdata_r;
endmodule

// File: src/pin_sync.sv
// Two-flop synchroniser for the serial bus pins
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = sram_spi_pkg::SYNC_W,
    parameter logic [sram_spi_pkg::SYNC_W-1:0] INIT = '0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [W-1:0] pins,
    output logic [W-1:0] synced
);
    import sram_spi_pkg::*;

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_r <= INIT;
            sync_r <= INIT;
        end else begin
            meta_r <= pins;
            sync_r <= meta_r;
        end
    end

    assign synced = sync_r;
endmodule

// File: src/serial_sram_spi_slave.sv
// Serial bus command and data front end of an 8192-byte SRAM
`timescale 1ns/10ps

// What this block does
// R1: Command bits shift into an 8-bit instruction register on rising serial clock.
// R2: Master keeps select low and hold high through an operation.
// R3: Instruction, address and data travel most significant bit first.
// R4: First input bit is taken on first rising clock after select falls.
// R5: After a hold pause the sequence continues exactly where it stopped.
// R6: Status bits 7:6 choose byte, page or sequential mode; 11 reserved.
// R7: Byte mode moves exactly one data byte after command and address.
// R8: Page mode increments within the 32-byte page and wraps to its start.
// R9: Sequential mode crosses pages and rolls 1FFFh over to 0000h.
// R10: Read command plus address shifts stored byte out; top three address bits ignored.
// R11: Page reads deliver 32 bytes before wrapping to byte 0 of page.
// R12: Raising select ends a read, stops output drive and drops the sequence.
// R13: Write takes address with top three bits ignored, then data bytes.
// R14: Page writes beyond 32 bytes wrap and overwrite earlier page bytes.
// R15: Opcodes 03 read, 02 write, 05 read status, 01 write status.
// R16: Read status returns the status register at any time, any mode.
// R17: Status bit 0 low enables hold pausing; high disables it.
// R18: Status bits 5:2 read zero, bit 1 reads one whatever is written.
// R19: Write status loads mode and hold enable from the following byte.
// R20: Starts in standby; a select falling edge is needed before a sequence.
// R21: Output updates after falling clock and floats while deselected.
// R22: Master changes hold only while clock is low, else it waits.
// R23: Reserved mode 11 behaves as byte mode.
// R24: Raising select clears instruction and address shift state.
module serial_sram_spi_slave (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    output logic so,
    output logic so_oe_n
);
    import sram_spi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Address stepping per mode

    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a, input logic [1:0] mode);
        logic [ADDR_W-1:0] n;
        n = a;
        unique case (mode)
            MODE_PAGE: n = {a[ADDR_W-1:PAGE_BITS], a[PAGE_BITS-1:0] + 1'b1}; // R8 R11 R14
            MODE_SEQ: n = a + 1'b1; // R9
            default: n = a; // R23
        endcase
        return n;
    endfunction

    function automatic logic single_byte(input logic [1:0] mode);
        return (mode != MODE_PAGE) && (mode != MODE_SEQ); // R7 R23
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and edge detection

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic hold_n_s;

    assign pins_raw = {hold_n, si, sck, cs_n};

    // Reset values match idle pins, so no false edge after reset
    pin_sync #(
        .W(SYNC_W),
        .INIT({1'b1, 1'b0, 1'b0, 1'b1})
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pins(pins_raw),
        .synced(pins_s)
    );

    assign cs_n_s = pins_s[SYNC_CS];
    assign sck_s = pins_s[SYNC_SCK];
    assign si_s = pins_s[SYNC_SI];
    assign hold_n_s = pins_s[SYNC_HOLD];

    logic sck_d_r;
    logic paused_r;
    logic [1:0] mode_r;
    logic hold_dis_r;
    logic hold_active;
    logic sck_rise;
    logic sck_fall;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sck_d_r <= 1'b0;
        end else begin
            sck_d_r <= sck_s;
        end
    end

    assign hold_active = ~hold_n_s & ~hold_dis_r; // R17

    // Pause and resume take effect only while the clock is low; deselect clears the pause at once
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            paused_r <= 1'b0;
        end else if (cs_n_s) begin
            paused_r <= 1'b0;
        end else if (!sck_s) begin
            paused_r <= hold_active; // R22
        end
    end

    // Edges while paused are ignored, state is left untouched
    assign sck_rise = sck_s & ~sck_d_r & ~cs_n_s & ~paused_r; // R5 R4
    assign sck_fall = ~sck_s & sck_d_r & ~cs_n_s & ~paused_r; // R5

    ////////////////////////////////////////////////////////////////////////////
    // Command, address and data sequencing

    seq_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [15:0] shift_r;
    logic [15:0] shift_nxt;
    logic is_read_r;
    logic [ADDR_W-1:0] addr_r;
    logic byte_done;

    assign shift_nxt = {shift_r[14:0], si_s}; // R3
    assign byte_done = (bit_cnt_r == BYTE_LAST);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shift_r <= '0;
        end else if (cs_n_s) begin
            shift_r <= '0; // R24
        end else if (sck_rise) begin
            shift_r <= shift_nxt; // R1
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_CMD; // R20
            bit_cnt_r <= '0;
            is_read_r <= 1'b0;
            addr_r <= '0;
        end else if (cs_n_s) begin
            state_r <= ST_CMD; // R24 R12
            bit_cnt_r <= '0;
            is_read_r <= 1'b0;
        end else if (sck_rise) begin
            unique case (state_r)
                ST_CMD: begin
                    if (byte_done) begin
                        bit_cnt_r <= '0;
                        unique case (shift_nxt[7:0]) // R15
                            CMD_READ: begin
                                state_r <= ST_ADDR;
                                is_read_r <= 1'b1;
                            end
                            CMD_WRITE: begin
                                state_r <= ST_ADDR;
                                is_read_r <= 1'b0;
                            end
                            READ_STATUS_CMD: state_r <= ST_STAT_RD; // R16
                            WRITE_STATUS_CMD: state_r <= ST_STAT_WR;
                            default: state_r <= ST_IGNORE;
                        endcase
                    end else begin
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                    end
                end
                ST_ADDR: begin
                    if (bit_cnt_r == ADDR_LAST) begin
                        bit_cnt_r <= '0;
                        addr_r <= shift_nxt[ADDR_W-1:0]; // R10 R13
                        state_r <= is_read_r ? ST_RD : ST_WR;
                    end else begin
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                    end
                end
                ST_WR, ST_RD: begin
                    if (byte_done) begin
                        bit_cnt_r <= '0;
                        addr_r <= next_addr(addr_r, mode_r);
                        if (single_byte(mode_r)) begin
                            state_r <= ST_IGNORE; // R7
                        end
                    end else begin
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                    end
                end
                ST_STAT_WR: begin
                    if (byte_done) begin
                        state_r <= ST_IGNORE;
                    end else begin
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                    end
                end
                ST_STAT_RD: begin
                    bit_cnt_r <= byte_done ? 4'h0 : bit_cnt_r + 1'b1;
                end
                ST_IGNORE: begin
                    bit_cnt_r <= '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status register

    logic [7:0] status_val;
    logic stat_commit;

    // Reserved bits and bit 1 are fixed, never stored
    assign status_val = {mode_r, STAT_RSVD_VAL, STAT_ONE_VAL, hold_dis_r}; // R18 R6
    assign stat_commit = sck_rise && (state_r == ST_STAT_WR) && byte_done;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_r <= MODE_RESET;
            hold_dis_r <= HOLD_DIS_RESET;
        end else if (stat_commit) begin
            mode_r <= shift_nxt[STAT_MODE_HI:STAT_MODE_LO]; // R19 R6
            hold_dis_r <= shift_nxt[STAT_HOLD_BIT]; // R19 R17
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte store access

    mem_port_if mem_if ();

    logic [ADDR_W-1:0] mem_addr_r;
    logic [DATA_W-1:0] mem_wdata_r;
    logic mem_wr_r;
    logic mem_rd_r;
    logic load_r;
    logic rd_first;
    logic rd_next;
    logic wr_commit;

    // Requests leave on the detected rising edge that completes a field
    assign rd_first = sck_rise && (state_r == ST_ADDR) && (bit_cnt_r == ADDR_LAST) && is_read_r;
    assign rd_next = sck_rise && (state_r == ST_RD) && byte_done && !single_byte(mode_r);
    assign wr_commit = sck_rise && (state_r == ST_WR) && byte_done;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_addr_r <= '0;
            mem_wdata_r <= '0;
            mem_wr_r <= 1'b0;
            mem_rd_r <= 1'b0;
        end else begin
            mem_wr_r <= 1'b0;
            mem_rd_r <= 1'b0;
            if (rd_first) begin
                mem_addr_r <= shift_nxt[ADDR_W-1:0]; // R10
                mem_rd_r <= 1'b1;
            end else if (rd_next) begin
                mem_addr_r <= next_addr(addr_r, mode_r); // R11 R9
                mem_rd_r <= 1'b1;
            end else if (wr_commit) begin
                mem_addr_r <= addr_r; // R13 R14
                mem_wdata_r <= shift_nxt[DATA_W-1:0];
                mem_wr_r <= 1'b1;
            end
        end
    end

    // Read data is one cycle behind the request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            load_r <= 1'b0;
        end else begin
            load_r <= mem_rd_r & ~cs_n_s;
        end
    end

    assign mem_if.addr = mem_addr_r;
    assign mem_if.wdata = mem_wdata_r;
    assign mem_if.wr_en = mem_wr_r;
    assign mem_if.rd_en = mem_rd_r;

    byte_store u_store (
        .ref_clk(ref_clk),
        .port(mem_if.store)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Serial output

    logic [DATA_W-1:0] tx_r;
    logic so_r;
    logic so_oe_n_r;
    logic reading;

    assign reading = (state_r == ST_RD) || (state_r == ST_STAT_RD);

    // Status preloaded after every opcode; only a status read shifts it out
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_r <= '0;
        end else if (cs_n_s) begin
            tx_r <= '0;
        end else if (load_r) begin
            tx_r <= mem_if.rdata;
        end else if (sck_rise && state_r == ST_CMD && byte_done) begin
            tx_r <= status_val; // R16
        end else if (sck_rise && state_r == ST_STAT_RD && byte_done) begin
            tx_r <= status_val;
        end else if (sck_fall && reading) begin
            tx_r <= {tx_r[DATA_W-2:0], 1'b0}; // R3
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            so_r <= 1'b0;
        end else if (cs_n_s) begin
            so_r <= 1'b0;
        end else if (sck_fall && reading) begin
            so_r <= tx_r[DATA_W-1]; // R21
        end
    end

    // Released while deselected, in hold or outside a read
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            so_oe_n_r <= 1'b1;
        end else begin
            so_oe_n_r <= cs_n_s | hold_active | paused_r | ~reading; // R12 R21
        end
    end

    assign so = so_r;
    assign so_oe_n = so_oe_n_r;
endmodule

// File: tb/serial_sram_spi_slave_bench.sv
// Self-checking bench for the serial SRAM slave
`timescale 1ns/10ps
module serial_sram_spi_slave_bench;
    import sram_spi_pkg::*;
    logic ref_clk;
    logic rst;
    wire logic cs_n;
    wire logic sck;
    wire logic si;
    wire logic hold_n;
    wire logic so;
    wire logic so_oe_n;
    int n_fail;
    int checks;
    logic [7:0] rx;
    logic oe;
    serial_sram_spi_slave dut (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .so(so), .so_oe_n(so_oe_n));
    spi_master_model m (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .so(so), .so_oe_n(so_oe_n));
    always #2 ref_clk = ~ref_clk;
    ////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [15:0] a);
        m.sel();
        m.xb(op, rx, oe);
        m.xb(a[15:8], rx, oe);
        m.xb(a[7:0], rx, oe);
    endtask
    task automatic wr_stat(input logic [7:0] s);
        m.sel();
        m.xb(WRITE_STATUS_CMD, rx, oe);
        m.xb(s, rx, oe);
        m.desel();
    endtask
    task automatic rd_stat(input logic [7:0] exp);
        m.sel();
        m.xb(READ_STATUS_CMD, rx, oe);
        m.xb(8'h00, rx, oe);
        m.desel();
        chk("status", exp, rx);
    endtask
    task automatic wait_oe(input logic v);
        int n;
        n = 0;
        while (so_oe_n !== v && n < 8) begin
            m.wait_clk(1);
            n++;
        end
        chk("oe wait", {7'h00, v}, {7'h00, so_oe_n});
        if (so_oe_n !== v) finish_test();
    endtask
    // Page content after 34 writes from offset 30
    function automatic logic [7:0] pg(input int o);
        return 8'h10 + 8'((o + 2) % 32) + (o >= 30 ? 8'h20 : 8'h00);
    endfunction
    ////////////////////////////////////////
    task automatic t_byte();
        cmd(CMD_WRITE, 16'hF234);
        m.xb(8'hA5, rx, oe);
        m.desel();
        cmd(CMD_READ, 16'h9234);
        m.xb(8'h00, rx, oe);
        chk("byte read", 8'hA5, rx);
        m.xb(8'h00, rx, oe);
        chk("oe second byte", 8'h01, {7'h00, oe});
        m.desel();
        chk("oe deselected", 8'h01, {7'h00, so_oe_n});
    endtask
    task automatic t_abort();
        m.sel();
        m.xb(CMD_WRITE, rx, oe);
        m.xb(8'h12, rx, oe);
        m.desel();
        m.sel();
        m.xb(8'h34, rx, oe);
        m.xb(8'h5A, rx, oe);
        m.desel();
        cmd(CMD_READ, 16'h1234);
        m.xb(8'h00, rx, oe);
        chk("after abort", 8'hA5, rx);
        m.desel();
    endtask
    task automatic t_page();
        wr_stat(8'h80);
        rd_stat(8'h82);
        cmd(CMD_WRITE, 16'h005E);
        for (int i = 0; i < 34; i++) m.xb(8'h10 + i[7:0], rx, oe);
        m.desel();
        cmd(CMD_READ, 16'h0040);
        for (int k = 0; k < 33; k++) begin
            m.xb(8'h00, rx, oe);
            chk("page read", pg(k % 32), rx);
        end
        m.desel();
    endtask
    task automatic t_seq();
        wr_stat(8'h40);
        cmd(CMD_WRITE, 16'h1FFF);
        m.xb(8'h3C, rx, oe);
        m.xb(8'hC3, rx, oe);
        m.desel();
        cmd(CMD_READ, 16'h0000);
        m.xb(8'h00, rx, oe);
        chk("write rollover", 8'hC3, rx);
        m.desel();
        cmd(CMD_READ, 16'h1FFF);
        m.xb(8'h00, rx, oe);
        chk("seq first", 8'h3C, rx);
        m.xb(8'h00, rx, oe);
        chk("read rollover", 8'hC3, rx);
        m.desel();
    endtask
    task automatic t_hold();
        cmd(CMD_READ, 16'h0040);
        m.xb(8'h00, rx, oe);
        m.pause(1'b0);
        wait_oe(1'b1);
        m.wait_clk(10);
        m.pause(1'b1);
        m.xb(8'h00, rx, oe);
        chk("after hold", pg(1), rx);
        m.desel();
        wr_stat(8'h41);
        rd_stat(8'h43);
        cmd(CMD_READ, 16'h0040);
        m.xb(8'h00, rx, oe);
        m.pause(1'b0);
        m.wait_clk(10);
        chk("hold disabled", 8'h00, {7'h00, so_oe_n});
        m.pause(1'b1);
        m.desel();
    endtask
    task automatic t_rsvd();
        wr_stat(8'hC0);
        rd_stat(8'hC2);
        cmd(CMD_READ, 16'h1234);
        m.xb(8'h00, rx, oe);
        chk("mode 11 read", 8'hA5, rx);
        m.xb(8'h00, rx, oe);
        chk("mode 11 oe", 8'h01, {7'h00, oe});
        m.desel();
    endtask
    ////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        n_fail = 0;
        checks = 0;
        repeat (2) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        m.wait_clk(4);
        chk("oe after reset", 8'h01, {7'h00, so_oe_n});
        rd_stat(8'h02);
        t_byte();
        t_abort();
        t_page();
        t_seq();
        t_hold();
        t_rsvd();
        finish_test();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        finish_test();
    end
endmodule

// File: tb/serial_sram_spi_slave_monitor.sv
// Pin-level assertion checker for the serial SRAM slave
`timescale 1ns/10ps
module serial_sram_spi_slave_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic so,
    input wire logic so_oe_n
);
    import sram_spi_pkg::*;
    logic sck_r;
    logic [5:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] op_r;
    logic [1:0] mode_r;
    logic hold_dis_r;
    wire rise = sck && !sck_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) sck_r <= 1'b0;
        else sck_r <= sck;
    end
    // Bit count and opcode of the frame as seen on the pins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 6'h00;
            sh_r <= 8'h00;
            op_r <= 8'h00;
        end else if (cs_n) begin
            cnt_r <= 6'h00;
            op_r <= 8'h00;
        end else if (rise) begin
            sh_r <= {sh_r[6:0], si};
            if (cnt_r != 6'h3F) cnt_r <= cnt_r + 6'h01;
            if (cnt_r == 6'h07) op_r <= {sh_r[6:0], si};
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_r <= MODE_RESET;
            hold_dis_r <= HOLD_DIS_RESET;
        end else if (!cs_n && rise && cnt_r == 6'h0F && op_r == WRITE_STATUS_CMD) begin
            mode_r <= sh_r[6:5];
            hold_dis_r <= si;
        end
    end
    ////////////////////////////////////////
    a_float_desel: assert property (cs_n [*6] |-> so_oe_n)
        else $error("output driven while deselected");
    a_reset_quiet: assert property ($fell(rst) |-> so_oe_n [*3])
        else $error("output driven after reset");
    a_cmd_silent: assert property (!cs_n && (cnt_r < 6'h08 || op_r == CMD_READ && cnt_r < 6'h18) |-> so_oe_n)
        else $error("output driven before command and address");
    a_oe_cause: assert property ($fell(so_oe_n) |->
        !cs_n && (op_r == READ_STATUS_CMD || op_r == CMD_READ && cnt_r >= 6'h18))
        else $error("output enabled without a read");
    a_other_silent: assert property (!cs_n && cnt_r >= 6'h08 && op_r != CMD_READ && op_r != READ_STATUS_CMD
        |-> so_oe_n)
        else $error("output driven for a non-read opcode");
    a_byte_once: assert property (!cs_n && op_r == CMD_READ && mode_r[1] == mode_r[0] && cnt_r >= 6'h22
        |-> so_oe_n)
        else $error("more than one byte in byte mode");
    a_so_steady: assert property (!so_oe_n && !$past(so_oe_n) && sck && $past(sck, 4) |-> $stable(so))
        else $error("output changed while clock high");
    a_hold_float: assert property ((!cs_n && !hold_dis_r && !hold_n) [*5] |-> so_oe_n)
        else $error("output driven while paused");
endmodule
bind serial_sram_spi_slave serial_sram_spi_slave_monitor mon (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n), .so(so), .so_oe_n(so_oe_n));

// File: tb/spi_master_model.sv
// Serial bus master model driving the slave pins
`timescale 1ns/10ps
module spi_master_model (
    input wire logic ref_clk,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    input wire logic so,
    input wire logic so_oe_n
);
    localparam int HALF = 10;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic sel();
        wait_clk(HALF);
        cs_n = 1'b0;
        wait_clk(HALF);
    endtask
    task automatic desel();
        cs_n = 1'b1;
        si = ~si;
        wait_clk(2 * HALF);
    endtask
    task automatic pause(input logic v);
        hold_n = v;
    endtask
    // Undriven output bits come back unknown
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx, output logic oe);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            wait_clk(HALF);
            rx[i] = so_oe_n ? 1'bx : so;
            oe = so_oe_n;
            sck = 1'b1;
            wait_clk(HALF);
            sck = 1'b0;
        end
    endtask
endmodule
